// ### rfil_consts.svh
// offsets, field values, reset values and timing counts of the regulator fault interrupt logic
`ifndef RFIL_CONSTS_SVH
`define RFIL_CONSTS_SVH
// ********************************
// register byte offsets
// ********************************
`define RFIL_OFF_TOP_FLAGS 5'h00
`define RFIL_OFF_BUCK_FLAGS 5'h04
`define RFIL_OFF_TOP_MASK 5'h08
`define RFIL_OFF_BUCK_MASK 5'h0C
`define RFIL_OFF_STATUS 5'h10
`define RFIL_OFF_CTRL 5'h14
// ********************************
// fields and reset values
// ********************************
`define RFIL_CTRL_EN_BIT 0
`define RFIL_CTRL_SWRST_BIT 1
`define RFIL_TOP_RST 4'h8
`define RFIL_TOP_NOMASK 4'h2
`define RFIL_BUCK_NOMASK 6'h10
// ********************************
// timing
// ********************************
`define RFIL_CLK_MHZ 125
`define RFIL_DEB_US 20
`define RFIL_SHORT_MS 1
`define RFIL_DEB_CYC (`RFIL_DEB_US * `RFIL_CLK_MHZ)
`define RFIL_SHORT_CYC (`RFIL_SHORT_MS * 1000 * `RFIL_CLK_MHZ)
`define RFIL_UVLO_CYC 1
`endif

// ### rfil_core.sv
// regulator fault interrupt logic: sticky flags, masks, irq pin and regulator gating
//
// Notes on behaviour
// - warnings set flag and irq only
// - protection sets flag, irq, disables regulator
// - faults shut the whole device down
// - any warning or protection sets flag, irq
// - irq low while any unmasked flag pending
// - fault shutdown reported by reset-seen flag afterwards
// - output low 1 ms: disable, short flag
// - load measurement done flag, maskable, no status
// - external reset release: defaults, reset-seen flag
// - supply glitch or software reset: restart, flag
// - current limit held 20 us sets phase flag
// - flags cleared by writing one
// - thermal shutdown flag sticky while hot, blocks enable
// - thermal warning flag sticky while warm
`timescale 1ns/1ps
`default_nettype none
`include "rfil_consts.svh"
module rfil_core #(
  parameter int CNT_W = 17,
  parameter int DEB_CYC = `RFIL_DEB_CYC,
  parameter int SHORT_CYC = `RFIL_SHORT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] ilim_active_i,
  input wire logic thermal_warn_i,
  input wire logic thermal_sd_i,
  input wire logic vout_low_i,
  input wire logic power_good_i,
  input wire logic load_meas_done_i,
  input wire logic main_supply_low_i,
  output logic reg_enable_o,
  output logic device_off_o,
  output logic irq_n_pin_o
);
  import rfil_pkg::*;

  // ********************************
  // declarations
  // ********************************
  logic [3:0] ilim_q; // filtered current limit per phase
  logic tw_q; // filtered thermal warning
  logic tsd_q; // filtered thermal shutdown
  logic pg_q; // filtered power good
  logic vlow_q; // output below threshold for the full window
  logic uvlo_q; // synchronised supply lockout
  rfil_top_s top_r; // sticky top flags
  rfil_buck_s buck_r; // sticky per-phase flags
  logic [3:0] top_mask_r; // 1 = masked
  logic [5:0] buck_mask_r; // 1 = masked
  logic ctrl_en_r; // software regulator enable
  logic sw_rst_r; // one-cycle software reset pulse
  logic pg_d_r; // edge detect of power good
  logic vlow_d_r; // edge detect of short trip
  rfil_bus_e state_r;
  logic [31:0] rd_val; // read mux
  logic sreset; // in-device reset to defaults
  logic wr_fire; // write takes effect this edge
  logic [7:0] wdat;
  rfil_top_s clr_top; // write-one-to-clear strobes
  rfil_buck_s clr_buck;
  logic sum_flag; // summary of all phase flags
  logic pend; // any unmasked flag
  logic short_rise, pg_rise;

  // ********************************
  // input filters
  // ********************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ilim
      // 20 us persistence on each phase current limit
      rfil_filter #(.CNT_W(CNT_W), .CNT(DEB_CYC)) u_ilim (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(1'b0), .d_i(ilim_active_i[g]), .q_o(ilim_q[g]));
    end
  endgenerate
  rfil_filter #(.CNT_W(CNT_W), .CNT(DEB_CYC)) u_tw (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(1'b0), .d_i(thermal_warn_i), .q_o(tw_q));
  rfil_filter #(.CNT_W(CNT_W), .CNT(DEB_CYC)) u_tsd (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(1'b0), .d_i(thermal_sd_i), .q_o(tsd_q));
  rfil_filter #(.CNT_W(CNT_W), .CNT(DEB_CYC)) u_pg (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(1'b0), .d_i(power_good_i), .q_o(pg_q));
  // window restarts at each enable, so start-up and overload share one counter
  rfil_filter #(.CNT_W(CNT_W), .CNT(SHORT_CYC)) u_short (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(!reg_enable_o), .d_i(vout_low_i), .q_o(vlow_q));
  // lockout acts at once, only synchronised
  rfil_filter #(.CNT_W(CNT_W), .CNT(`RFIL_UVLO_CYC)) u_uvlo (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(1'b0), .d_i(main_supply_low_i), .q_o(uvlo_q));

  // ********************************
  // decode
  // ********************************
  assign sreset = uvlo_q | sw_rst_r;
  assign wr_fire = (state_r == BUS_ACK) && avs_write_i && avs_byteenable_i[0];
  assign wdat = avs_writedata_i[7:0];
  assign clr_top = (wr_fire && avs_address_i == `RFIL_OFF_TOP_FLAGS) ? rfil_top_s'(wdat[4:1]) : '0;
  assign clr_buck = (wr_fire && avs_address_i == `RFIL_OFF_BUCK_FLAGS) ? rfil_buck_s'(wdat[5:0]) : '0;
  assign sum_flag = |buck_r;
  assign short_rise = vlow_q & ~vlow_d_r;
  assign pg_rise = pg_q & ~pg_d_r;
  // unmaskable bits ignore their mask
  assign pend = |(top_r & ~(top_mask_r & ~`RFIL_TOP_NOMASK))
    | |(buck_r & ~(buck_mask_r & ~`RFIL_BUCK_NOMASK));

  // ********************************
  // avalon slave
  // ********************************
  // read mux; unmapped addresses read zero
  always_comb begin
    case (avs_address_i)
      `RFIL_OFF_TOP_FLAGS: rd_val = {27'h0, top_r, sum_flag};
      `RFIL_OFF_BUCK_FLAGS: rd_val = {26'h0, buck_r};
      `RFIL_OFF_TOP_MASK: rd_val = {27'h0, top_mask_r, 1'b0};
      `RFIL_OFF_BUCK_MASK: rd_val = {26'h0, buck_mask_r};
      `RFIL_OFF_STATUS: rd_val = {24'h0, reg_enable_o, pg_q, tsd_q, tw_q, ilim_q};
      `RFIL_OFF_CTRL: rd_val = {31'h0, ctrl_en_r};
      default: rd_val = 32'h0;
    endcase
  end

  // every access takes exactly one wait cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      case (state_r)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            state_r <= BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= avs_read_i ? rd_val : 32'h0;
          end
        end
        BUS_ACK: begin
          // request completes at this edge
          state_r <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          state_r <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ********************************
  // control and mask registers
  // ********************************
  // in-device reset brings these back to defaults too
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_en_r <= 1'b0;
      top_mask_r <= 4'h0;
      buck_mask_r <= 6'h00;
    end else if (sreset) begin
      ctrl_en_r <= 1'b0;
      top_mask_r <= 4'h0;
      buck_mask_r <= 6'h00;
    end else if (wr_fire) begin
      if (avs_address_i == `RFIL_OFF_CTRL) begin
        ctrl_en_r <= wdat[`RFIL_CTRL_EN_BIT];
      end
      if (avs_address_i == `RFIL_OFF_TOP_MASK) begin
        top_mask_r <= wdat[4:1];
      end
      if (avs_address_i == `RFIL_OFF_BUCK_MASK) begin
        buck_mask_r <= wdat[5:0];
      end
    end
  end

  // software reset bit self-clears after one cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_rst_r <= 1'b0;
    end else begin
      sw_rst_r <= wr_fire && avs_address_i == `RFIL_OFF_CTRL && wdat[`RFIL_CTRL_SWRST_BIT];
    end
  end

  // ********************************
  // sticky flags
  // ********************************
  // edge history for one-shot events
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vlow_d_r <= 1'b0;
      pg_d_r <= 1'b0;
    end else begin
      vlow_d_r <= vlow_q;
      pg_d_r <= pg_q;
    end
  end

  // set wins over clear; level-set flags refuse to clear while the cause is live
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      top_r <= `RFIL_TOP_RST;
      buck_r <= '0;
    end else if (sreset) begin
      // fault or software reset: defaults, restart reported by reset-seen
      top_r <= `RFIL_TOP_RST;
      buck_r <= '0;
    end else begin
      top_r.tw <= tw_q | (top_r.tw & ~clr_top.tw);
      top_r.tsd <= tsd_q | (top_r.tsd & ~clr_top.tsd);
      top_r.load <= load_meas_done_i | (top_r.load & ~clr_top.load);
      top_r.rst_seen <= top_r.rst_seen & ~clr_top.rst_seen;
      buck_r.ilim <= ilim_q | (buck_r.ilim & ~clr_buck.ilim);
      buck_r.shrt <= short_rise | (buck_r.shrt & ~clr_buck.shrt);
      buck_r.pg <= pg_rise | (buck_r.pg & ~clr_buck.pg);
    end
  end

  // ********************************
  // outputs
  // ********************************
  // warnings never enter the enable term, only protections do
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_enable_o <= 1'b0;
      device_off_o <= 1'b0;
      irq_n_pin_o <= 1'b1;
    end else begin
      reg_enable_o <= ctrl_en_r & ~buck_r.shrt & ~top_r.tsd & ~tsd_q & ~sreset;
      device_off_o <= uvlo_q;
      irq_n_pin_o <= ~pend;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_irq_low;
    pend |=> !irq_n_pin_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq not low with pending flag");

  property p_irq_rel;
    !pend ##1 !pend |=> irq_n_pin_o;
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq low without pending flag");

  property p_short;
    short_rise && !sreset |=> buck_r.shrt ##1 !reg_enable_o;
  endproperty
  a_short: assert property (p_short) else $error("short did not flag and disable");

  property p_tsd_block;
    top_r.tsd |=> !reg_enable_o;
  endproperty
  a_tsd_block: assert property (p_tsd_block) else $error("enable with thermal shutdown pending");

  // checks the mask override apart from the pending term itself
  property p_nomask;
    top_r.tsd || buck_r.shrt |=> !irq_n_pin_o;
  endproperty
  a_nomask: assert property (p_nomask) else $error("unmaskable flag did not pull irq low");

  property p_tsd_hold;
    tsd_q && !sreset |=> top_r.tsd;
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("thermal shutdown flag cleared while hot");

  property p_tw_hold;
    tw_q && !sreset |=> top_r.tw;
  endproperty
  a_tw_hold: assert property (p_tw_hold) else $error("thermal warning flag cleared while warm");

  property p_warn_run;
    ctrl_en_r && !buck_r.shrt && !top_r.tsd && !tsd_q && !sreset && top_r.tw |=> reg_enable_o;
  endproperty
  a_warn_run: assert property (p_warn_run) else $error("warning changed regulator state");

  property p_reset_seen;
    sreset |=> top_r.rst_seen && !reg_enable_o;
  endproperty
  a_reset_seen: assert property (p_reset_seen) else $error("reset not reported");

  property p_ilim;
    ilim_q[0] && !sreset |=> buck_r.ilim[0] && sum_flag;
  endproperty
  a_ilim: assert property (p_ilim) else $error("current limit flag or summary missing");

  property p_load;
    load_meas_done_i && !sreset |=> top_r.load;
  endproperty
  a_load: assert property (p_load) else $error("load measurement flag missing");

  property p_bus;
    state_r == BUS_IDLE && (avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// ### rfil_filter.sv
// three-flop synchroniser with a symmetric persistence filter
`timescale 1ns/1ps
`default_nettype none
module rfil_filter #(
  parameter int CNT_W = 17,
  parameter int CNT = 2500
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic d_i,
  output logic q_o
);
  // ********************************
  // synchroniser
  // ********************************
  logic [2:0] s_r; // s_r[0] is read only by s_r[1]
  logic [CNT_W-1:0] cnt_r; // cycles the new level has held
  logic agree; // second and third stage match

  // shift the pin in
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= 3'h0;
    end else begin
      s_r <= {s_r[1:0], d_i};
    end
  end

  assign agree = (s_r[1] == s_r[2]);

  // ********************************
  // persistence counter
  // ********************************
  // output follows only after the level held CNT cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      q_o <= 1'b0;
    end else if (clr_i) begin
      // clear restarts the window, e.g. on regulator enable
      cnt_r <= '0;
      q_o <= 1'b0;
    end else if (!agree || s_r[2] == q_o) begin
      cnt_r <= '0;
    end else if (cnt_r == CNT_W'(CNT - 1)) begin
      cnt_r <= '0;
      q_o <= s_r[2];
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// ### rfil_host.sv
// host model: bus master that reads and clears the interrupt flags
`timescale 1ns/1ps
`default_nettype none
module rfil_host (
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [4:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  // ****************************************
  // idle bus at time zero
  // ****************************************
  initial begin
    address_o = 5'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'hF;
  end
  // ****************************************
  // one access, held until waitrequest is seen low
  // ****************************************
  // a write of ones clears flags; the master never assumes a latency
  task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address_o <= a;
    read_o <= !w;
    write_o <= w;
    writedata_o <= d;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    // released lines show a fresh pattern so a stale value cannot pass
    address_o <= ~a;
    writedata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ### rfil_pkg.sv
// types shared by the regulator fault interrupt logic
`default_nettype none
package rfil_pkg;
  // top flag group, bits [4:1] of the top flag register
  typedef struct packed {
    logic rst_seen;
    logic load;
    logic tsd;
    logic tw;
  } rfil_top_s;
  // per-phase flag group, bits [5:0] of the buck flag register
  typedef struct packed {
    logic pg;
    logic shrt;
    logic [3:0] ilim;
  } rfil_buck_s;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } rfil_bus_e;
endpackage
`default_nettype wire

// ### tb.sv
// self-checking testbench for the regulator fault interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "rfil_consts.svh"
module tb;
  import rfil_pkg::*;
  localparam logic [4:0] TOPF = `RFIL_OFF_TOP_FLAGS;
  localparam logic [4:0] BUCKF = `RFIL_OFF_BUCK_FLAGS;
  localparam logic [4:0] TOPM = `RFIL_OFF_TOP_MASK;
  localparam logic [4:0] BUCKM = `RFIL_OFF_BUCK_MASK;
  localparam logic [4:0] CTRL = `RFIL_OFF_CTRL;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] adr;
  logic rd;
  logic wr_en;
  logic [31:0] wdat;
  logic [3:0] be;
  logic [31:0] rdat;
  logic wreq;
  logic [3:0] ilim_i = 4'h0; // pins start quiet
  logic warn_i = 1'b0;
  logic sd_i = 1'b0;
  logic vlow_i = 1'b0;
  logic pg_i = 1'b0;
  logic load_i = 1'b0;
  logic supply_i = 1'b0;
  logic reg_en;
  logic dev_off;
  logic irq_n;
  int errors = 0;
  int total_checks = 0;
  integer seed = 32'h9DEF;
  logic [3:0] ph;
  // reference model: expected flags and masks
  logic [4:0] m_top = 5'h10;
  logic [5:0] m_buck = 6'h00;
  logic [4:0] m_tmask = 5'h00;
  logic [5:0] m_bmask = 6'h00;
  // ****************************************
  // clock, design and host
  // ****************************************
  always #4 clk_i = ~clk_i;
  // short counts keep the run brief; expectations use settle below
  rfil_core #(.CNT_W(5), .DEB_CYC(4), .SHORT_CYC(16)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr_en), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .ilim_active_i(ilim_i), .thermal_warn_i(warn_i), .thermal_sd_i(sd_i), .vout_low_i(vlow_i),
    .power_good_i(pg_i), .load_meas_done_i(load_i), .main_supply_low_i(supply_i),
    .reg_enable_o(reg_en), .device_off_o(dev_off), .irq_n_pin_o(irq_n));
  rfil_host host (.clk_i(clk_i), .waitrequest_i(wreq), .readdata_i(rdat), .address_o(adr),
    .read_o(rd), .write_o(wr_en), .writedata_o(wdat), .byteenable_o(be));
  // ****************************************
  // check helpers
  // ****************************************
  // shutdown and short bits cannot be masked
  function automatic logic exp_irq();
    return !(|(m_top & ~m_tmask & 5'h1A) | m_top[2] | |(m_buck & ~m_bmask & 6'h2F) | m_buck[4]);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(a, 1'b1, d, q);
  endtask
  task automatic topchk();
    rchk(TOPF, {27'h0, m_top[4:1], |m_buck});
  endtask
  // irq is registered one cycle after its flag, so let it land
  task automatic irqchk();
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_n}, {31'h0, exp_irq()});
  endtask
  task automatic enchk(input logic e);
    repeat (3) @(posedge clk_i);
    chk({31'h0, reg_en}, {31'h0, e});
  endtask
  // pins pass synchroniser and filter before a flag moves
  task automatic settle();
    repeat (40) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    repeat (6000) @(posedge clk_i);
    errors++;
    complete_run();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // start-up flag, unmapped read, clear by one
    irqchk();
    topchk();
    rchk(5'h1C, 32'h0);
    wr(TOPF, 32'h10);
    m_top = 5'h00;
    topchk();
    irqchk();
    $display("test 1 done");
    // warning leaves the regulator running; clear refused while warm
    wr(CTRL, 32'h1);
    enchk(1'b1);
    @(posedge clk_i) warn_i <= 1'b1;
    settle();
    m_top[1] = 1'b1;
    topchk();
    enchk(1'b1);
    // live view: regulator on, warning live, nothing else
    rchk(`RFIL_OFF_STATUS, 32'h90);
    wr(TOPF, 32'h2);
    topchk();
    irqchk();
    @(posedge clk_i) warn_i <= 1'b0;
    settle();
    wr(TOPF, 32'h2);
    m_top = 5'h00;
    topchk();
    irqchk();
    $display("test 2 done");
    // masked load flag still sets but keeps irq released
    wr(TOPM, 32'h8);
    m_tmask = 5'h08;
    @(posedge clk_i) load_i <= 1'b1;
    @(posedge clk_i) load_i <= 1'b0;
    settle();
    m_top[3] = 1'b1;
    topchk();
    irqchk();
    wr(TOPF, 32'h8);
    m_top = 5'h00;
    $display("test 3 done");
    // random phases in current limit, summary follows
    ph = 4'($random(seed)) | 4'h1;
    @(posedge clk_i) ilim_i <= ph;
    settle();
    m_buck = {2'b00, ph};
    rchk(BUCKF, {28'h0, ph});
    topchk();
    irqchk();
    enchk(1'b1);
    @(posedge clk_i) ilim_i <= 4'h0;
    settle();
    wr(BUCKF, {28'h0, ph});
    m_buck = 6'h00;
    topchk();
    irqchk();
    // power good masked; short mask bit has no effect
    wr(BUCKM, 32'h30);
    m_bmask = 6'h30;
    @(posedge clk_i) pg_i <= 1'b1;
    settle();
    m_buck[5] = 1'b1;
    rchk(BUCKF, 32'h20);
    irqchk();
    wr(BUCKF, 32'h20);
    m_buck = 6'h00;
    $display("test 4 done");
    // output held low: regulator off, unmaskable short flag
    @(posedge clk_i) vlow_i <= 1'b1;
    settle();
    m_buck[4] = 1'b1;
    enchk(1'b0);
    rchk(BUCKF, 32'h10);
    topchk();
    irqchk();
    @(posedge clk_i) vlow_i <= 1'b0;
    settle();
    wr(BUCKF, 32'h10);
    m_buck = 6'h00;
    enchk(1'b1);
    irqchk();
    $display("test 5 done");
    // shutdown: flag sticky while hot and blocks enable while pending
    @(posedge clk_i) sd_i <= 1'b1;
    settle();
    m_top[2] = 1'b1;
    enchk(1'b0);
    wr(TOPF, 32'h4);
    topchk();
    @(posedge clk_i) sd_i <= 1'b0;
    settle();
    enchk(1'b0);
    irqchk();
    wr(TOPF, 32'h4);
    m_top = 5'h00;
    enchk(1'b1);
    $display("test 6 done");
    // software reset restores defaults and reports itself
    wr(CTRL, 32'h2);
    m_top = 5'h10;
    m_tmask = 5'h00;
    m_bmask = 6'h00;
    enchk(1'b0);
    topchk();
    rchk(TOPM, 32'h0);
    irqchk();
    wr(TOPF, 32'h10);
    m_top = 5'h00;
    // supply lockout shuts the device down, flag after start-up
    // three sync flops, filter edge and output flop: settled well inside 8 cycles
    @(posedge clk_i) supply_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({31'h0, dev_off}, 32'h1);
    @(posedge clk_i) supply_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({31'h0, dev_off}, 32'h0);
    m_top = 5'h10;
    topchk();
    wr(TOPF, 32'h10);
    m_top = 5'h00;
    // external reset in mid-run
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    m_top = 5'h10;
    topchk();
    irqchk();
    $display("test 7 done");
    complete_run();
  end
endmodule
`default_nettype wire
